// ### rtl/flash_self_program_control.sv
// flash self-programming control: status register, store window, page buffer
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control
  import spm_ctrl_pkg::*;
#(
  parameter int ERASE_CNT = ERASE_CYCLES,
  parameter int WRITE_CNT = WRITE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  // register port from the core
  input wire logic csr_wr,
  input wire logic [7:0] csr_wdata,
  output logic [7:0] csr_rdata,
  input wire logic global_irq_en,
  // instruction strobes from the core
  input wire logic store_program_instr,
  input wire logic load_program_instr,
  input wire logic [15:0] pointer,
  input wire logic [7:0] source_low_byte,
  input wire logic [7:0] source_high_byte,
  input wire logic [7:0] sig_byte_lo,
  input wire logic [7:0] sig_byte_hi,
  input wire logic [7:0] lock_bits_in,
  input wire logic [7:0] fuse_bits_in,
  output logic special_read,
  output logic [7:0] special_rdata,
  // flash array side
  output flash_req_t flash_req,
  output logic flash_req_valid,
  output logic [15:0] buf_word [PAGE_WORDS],
  output logic [PAGE_WORDS-1:0] buf_loaded,
  output logic readable_section_busy,
  output logic core_stall,
  output logic program_ready_irq
);
  // a zero count would never finish an operation
  if (ERASE_CNT < 1 || WRITE_CNT < 1) $error("op counts must be >= 1");

  logic irq_en_q, busy_q, sig_q, reen_q, lock_q, pgwr_q, pger_q, spen_q;
  logic [2:0] win_q;
  logic op_run_q, op_halt_q, op_rww_q;
  logic [31:0] op_cnt_q;
  logic fill_act_q;

  function automatic spm_op_t decode(input logic [5:0] b);
    case (b[4:0])
      PAT_REEN: decode = OP_REEN;
      PAT_LOCK: decode = OP_LOCK;
      PAT_PGWR: decode = OP_WRITE;
      PAT_PGER: decode = OP_ERASE;
      PAT_FILL: decode = b[5] ? OP_SIG : OP_FILL;
      default: decode = OP_NONE;
    endcase
  endfunction

  spm_op_t wr_op;
  assign wr_op = decode(csr_wdata[5:0]);
  wire logic arm = csr_wr && wr_op != OP_NONE && !op_run_q && !spen_q;
  wire logic window_open = spen_q && !op_run_q && win_q != 3'h0;
  wire logic store_hit = window_open && store_program_instr;
  wire logic [7:0] ptr_page = pointer[14:7];
  wire logic [5:0] ptr_word = pointer[6:1];
  wire logic page_halts = ptr_page >= HALT_FIRST_PAGE;

  // interrupt enable is plain storage
  always_ff @(posedge mclk) begin
    if (!rstn) irq_en_q <= 1'b0;
    else if (csr_wr) irq_en_q <= csr_wdata[BIT_IRQ_EN];
  end

  // command bits and store enable; window countdown
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      {sig_q, reen_q, lock_q, pgwr_q, pger_q, spen_q} <= 6'h00;
      win_q <= 3'h0;
    end else if (arm) begin
      {sig_q, reen_q, lock_q, pgwr_q, pger_q, spen_q} <= csr_wdata[5:0];
      win_q <= 3'(STORE_WINDOW);
    end else if (op_run_q) begin
      if (op_cnt_q == 32'd1) begin
        {sig_q, reen_q, lock_q, pgwr_q, pger_q, spen_q} <= 6'h00;
      end
    end else if (store_hit) begin
      if (!(pgwr_q || pger_q || lock_q)) begin
        {sig_q, reen_q, lock_q, pgwr_q, pger_q, spen_q} <= 6'h00;
      end
      win_q <= 3'h0;
    end else if (spen_q) begin
      win_q <= win_q - 3'h1;
      if (win_q == 3'h1) begin
        {sig_q, reen_q, lock_q, pgwr_q, pger_q, spen_q} <= 6'h00;
      end
    end
  end

  // long operation timer
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      op_run_q <= 1'b0;
      op_cnt_q <= 32'd0;
      op_halt_q <= 1'b0;
      op_rww_q <= 1'b0;
    end else if (op_run_q) begin
      op_cnt_q <= op_cnt_q - 32'd1;
      if (op_cnt_q == 32'd1) begin
        op_run_q <= 1'b0;
        op_halt_q <= 1'b0;
      end
    end else if (store_hit && (pgwr_q || pger_q || lock_q)) begin
      op_run_q <= 1'b1;
      op_cnt_q <= pgwr_q ? 32'(WRITE_CNT) :
        pger_q ? 32'(ERASE_CNT) : 32'(LOCK_CYCLES);
      op_halt_q <= (pgwr_q || pger_q) && page_halts;
      op_rww_q <= (pgwr_q || pger_q) && !page_halts;
    end
  end

  // section busy: set on readable erase/write, clear on reenable or fill
  always_ff @(posedge mclk) begin
    if (!rstn) busy_q <= 1'b0;
    else if (store_hit && (pgwr_q || pger_q) && !page_halts)
      busy_q <= 1'b1;
    else if (store_hit && reen_q) busy_q <= 1'b0;
    else if (store_hit && spen_q && !(sig_q || reen_q || lock_q ||
             pgwr_q || pger_q)) busy_q <= 1'b0;
  end

  // temporary page buffer, held here so an abort can drop it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      buf_loaded <= '0;
      fill_act_q <= 1'b0;
    end else if (csr_wr && wr_op == OP_REEN && fill_act_q) begin
      buf_loaded <= '0;
      fill_act_q <= 1'b0;
    end else if (store_hit && spen_q && !(sig_q || reen_q || lock_q ||
                 pgwr_q || pger_q)) begin
      buf_word[ptr_word] <= {source_high_byte, source_low_byte};
      buf_loaded[ptr_word] <= 1'b1;
      fill_act_q <= 1'b1;
    end else if (store_hit && pgwr_q) begin
      buf_loaded <= '0; // buffer consumed by page write
      fill_act_q <= 1'b0;
    end
  end

  // flash request, one pulse when a long op starts
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flash_req_valid <= 1'b0;
      flash_req <= '0;
    end else begin
      flash_req_valid <= store_hit && !op_run_q && (pgwr_q || pger_q ||
        lock_q);
      if (store_hit) begin
        flash_req.erase <= pger_q;
        flash_req.write <= pgwr_q;
        flash_req.lock <= lock_q;
        flash_req.page <= ptr_page;
        flash_req.lock_data <= source_low_byte;
      end
    end
  end

  // special loads: signature, lock or fuse within three cycles of arming
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      special_read <= 1'b0;
      special_rdata <= 8'h00;
    end else begin
      special_read <= 1'b0;
      if (load_program_instr && window_open &&
          win_q > 3'(STORE_WINDOW - LOAD_WINDOW)) begin
        if (sig_q) begin
          special_read <= 1'b1;
          special_rdata <= pointer[0] ? sig_byte_hi : sig_byte_lo;
        end else if (lock_q) begin
          special_read <= 1'b1;
          special_rdata <= pointer[0] ? fuse_bits_in : lock_bits_in;
        end
      end
    end
  end

  assign csr_rdata = {irq_en_q, busy_q, sig_q, reen_q, lock_q, pgwr_q,
                      pger_q, spen_q};
  assign readable_section_busy = busy_q;
  assign core_stall = op_halt_q;
  assign program_ready_irq = irq_en_q && global_irq_en && !spen_q;

  // checks
  a_irq_level: assert property (@(posedge mclk) disable iff (!rstn)
    program_ready_irq == (irq_en_q && global_irq_en && !spen_q))
    else $error("ready irq wrong");
  a_window_expire: assert property (@(posedge mclk) disable iff (!rstn)
    (arm && wr_op == OP_FILL) ##1 !store_program_instr [*4] |=> !spen_q)
    else $error("store enable outlived window");
  a_busy_set: assert property (@(posedge mclk) disable iff (!rstn)
    store_hit && (pgwr_q || pger_q) && !page_halts |=> busy_q)
    else $error("busy not set");
  a_stall_spen: assert property (@(posedge mclk) disable iff (!rstn)
    core_stall |-> spen_q)
    else $error("stall without busy");
  a_spen_hold: assert property (@(posedge mclk) disable iff (!rstn)
    op_run_q && op_cnt_q > 32'd1 |=> spen_q)
    else $error("store enable dropped early");
  a_bad_pattern: assert property (@(posedge mclk) disable iff (!rstn)
    csr_wr && wr_op == OP_NONE && !spen_q |=> !spen_q)
    else $error("bad pattern acted");
  a_abort_fill: assert property (@(posedge mclk) disable iff (!rstn)
    csr_wr && wr_op == OP_REEN && fill_act_q |=> buf_loaded == '0)
    else $error("fill not aborted");
  a_fill_clear: assert property (@(posedge mclk) disable iff (!rstn)
    store_hit && wr_op != OP_NONE && spen_q && !(sig_q || reen_q ||
    lock_q || pgwr_q || pger_q) && !(store_hit && (pgwr_q || pger_q))
    |=> !busy_q)
    else $error("busy kept on fill");
  c_fill: cover property (@(posedge mclk) store_hit && !pgwr_q && !pger_q);
  c_erase: cover property (@(posedge mclk) store_hit && pger_q);
  c_stall: cover property (@(posedge mclk) core_stall);
  c_sig: cover property (@(posedge mclk) special_read);
endmodule
`default_nettype wire

// ### rtl/spm_ctrl_pkg.sv
// constants and carrier types for the flash self-programming control block
// What this block does
// - flash splits at word 0x3800: 224 readable pages below, 32 halting pages above
// - program word counter is 14 bits; low six bits pick word in page
// - page index from pointer bits 14..7, word index from bits 6..1
// - pointer bit 15 ignored; bit 0 zero for stores, byte select for loads
// - eight-bit control/status register at 0x37 (0x57), resets to zero
// - ready interrupt requested while enabled, global enable set, store enable clear
// - erase/write to readable region sets busy flag and blocks that region
// - busy cleared by re-enable after completion, or by starting buffer load
// - signature select: load within three cycles reads signature; store does nothing
// - re-enable with store enable plus store restores access; refused while busy
// - re-enable written during buffer load aborts load, discards buffered data
// - lock set plus store programs lock bits from low source; select auto-clears
// - load within three cycles after lock set returns lock or fuse by bit 0
// - page write plus store writes buffer to pointer page; select auto-clears
// - page erase plus store erases pointer page; select auto-clears
// - core stalled for whole erase or write of a halting-region page
// - store enable alone: store puts source pair into buffer word at pointer
// - four-cycle store window; store enable clears on completion or expiry
// - store enable stays set during erase or write as busy indication
// - only low-five patterns 10001 01001 00101 00011 00001 take effect
package spm_ctrl_pkg;
  localparam logic [5:0] CSR_IO_ADDR = 6'h37;
  localparam logic [7:0] CSR_MEM_ADDR = 8'h57;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_SIG = 5;
  localparam int BIT_REEN = 4;
  localparam int BIT_LOCK = 3;
  localparam int BIT_PGWR = 2;
  localparam int BIT_PGER = 1;
  localparam int BIT_SPEN = 0;
  localparam logic [4:0] PAT_REEN = 5'h11;
  localparam logic [4:0] PAT_LOCK = 5'h09;
  localparam logic [4:0] PAT_PGWR = 5'h05;
  localparam logic [4:0] PAT_PGER = 5'h03;
  localparam logic [4:0] PAT_FILL = 5'h01;
  localparam logic [4:0] PAT_SIG = 5'h21 & 5'h1F; // low five of sig|en
  localparam int PC_BITS = 14;
  localparam int WORD_BITS = 6;
  localparam int PAGE_BITS = PC_BITS - WORD_BITS;
  localparam int PAGE_WORDS = 64;
  localparam logic [7:0] HALT_FIRST_PAGE = 8'hE0; // word 0x3800 / 64 = 224
  localparam int STORE_WINDOW = 4;
  localparam int LOAD_WINDOW = 3;
  // operation times in ns
  localparam int ERASE_TIME_NS = 40000;
  localparam int WRITE_TIME_NS = 40000;
  localparam int LOCK_TIME_NS = 100;
  localparam int CLK_NS = 10;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    OP_NONE, OP_FILL, OP_ERASE, OP_WRITE, OP_LOCK, OP_REEN, OP_SIG
  } spm_op_t;

  // request to the flash array
  typedef struct packed {
    logic erase;
    logic write;
    logic lock;
    logic [7:0] page;
    logic [7:0] lock_data;
  } flash_req_t;
endpackage

// ### verif/core_model.sv
// core model: issues store and load program instructions
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic mclk,
  output logic store_program_instr,
  output logic load_program_instr,
  output logic [15:0] pointer,
  output logic [7:0] source_low_byte,
  output logic [7:0] source_high_byte
);
  // idle core, no instruction pending
  initial begin
    store_program_instr = 1'b0;
    load_program_instr = 1'b0;
    pointer = 16'h0000;
    {source_high_byte, source_low_byte} = 16'h0000;
  end
  // one store; page writes also get a zero word index
  task automatic store(input logic [15:0] z, input logic [15:0] d,
                       input logic pg);
    pointer = pg ? (z & 16'hFF80) : (z & 16'hFFFE);
    {source_high_byte, source_low_byte} = d;
    store_program_instr = 1'b1;
    @(posedge mclk) #1;
    store_program_instr = 1'b0;
    pointer = ~pointer; // stale operands must not look valid
    {source_high_byte, source_low_byte} = ~d;
  endtask
  // one load; bit 0 picks the byte
  task automatic load(input logic [15:0] z);
    pointer = z;
    load_program_instr = 1'b1;
    @(posedge mclk) #1;
    load_program_instr = 1'b0;
    pointer = ~z;
  endtask
endmodule
`default_nettype wire

// ### verif/flash_self_program_control_test.sv
// self-checking bench for the flash self-programming control block
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control_test;
  import spm_ctrl_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic csr_wr = 1'b0;
  logic [7:0] csr_wdata = 8'h00;
  logic global_irq_en = 1'b0;
  logic [7:0] sig_lo, sig_hi, lock_in, fuse_in;
  logic store, load, special_read, flash_req_valid, busy, stall, irq;
  logic [15:0] pointer, d, z;
  logic [7:0] bad [3] = '{8'h07, 8'h13, 8'h0D};
  logic [7:0] src_lo, src_hi, csr_rdata, special_rdata, pg;
  logic [15:0] buf_word [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] buf_loaded;
  flash_req_t flash_req, mk;
  logic [7:0] rd_q[$];
  flash_req_t req_q[$], msk_q[$];
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 32'h1f452fe5;
  always #5 mclk = ~mclk;
  core_model core (.mclk(mclk), .store_program_instr(store),
    .load_program_instr(load), .pointer(pointer),
    .source_low_byte(src_lo), .source_high_byte(src_hi));
  flash_self_program_control #(.ERASE_CNT(10), .WRITE_CNT(10)) dut (
    .mclk(mclk), .rstn(rstn), .csr_wr(csr_wr), .csr_wdata(csr_wdata),
    .csr_rdata(csr_rdata), .global_irq_en(global_irq_en),
    .store_program_instr(store), .load_program_instr(load),
    .pointer(pointer), .source_low_byte(src_lo), .source_high_byte(src_hi),
    .sig_byte_lo(sig_lo), .sig_byte_hi(sig_hi), .lock_bits_in(lock_in),
    .fuse_bits_in(fuse_in), .special_read(special_read),
    .special_rdata(special_rdata), .flash_req(flash_req),
    .flash_req_valid(flash_req_valid), .buf_word(buf_word),
    .buf_loaded(buf_loaded), .readable_section_busy(busy),
    .core_stall(stall), .program_ready_irq(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic sync();
    @(posedge mclk) #1;
  endtask
  task automatic arm(input logic [7:0] v);
    csr_wr = 1'b1;
    csr_wdata = v;
    sync();
    csr_wr = 1'b0;
  endtask
  // note one expected flash request with the fields that matter
  task automatic want(input flash_req_t v, input flash_req_t m);
    req_q.push_back(v);
    msk_q.push_back(m);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100 && csr_rdata[BIT_SPEN] !== 1'b0; i++) sync();
    @(negedge mclk);
  endtask
  // monitor: each result takes the oldest note
  always @(negedge mclk) begin
    if (special_read === 1'b1) begin
      if (rd_q.size() == 0) check(1, 0);
      else check(special_rdata, rd_q.pop_front());
    end
    if (flash_req_valid === 1'b1) begin
      if (req_q.size() == 0) check(2, 0);
      else begin
        mk = msk_q.pop_front();
        check(flash_req & mk, req_q.pop_front() & mk);
      end
    end
  end
  // watchdog well beyond the expected run of about a hundred cycles
  initial begin
    #50000;
    n_mismatch++;
    final_report();
  end
  initial begin
    {sig_lo, sig_hi, lock_in, fuse_in} = $random(seed);
    repeat (10) @(posedge mclk);
    #1 rstn = 1'b1;
    @(negedge mclk) check(csr_rdata, CSR_RESET);
    sync();
    global_irq_en = 1'b1;
    arm(8'h81);
    @(negedge mclk) check(irq, 1'b0);
    repeat (5) sync();
    check({irq, csr_rdata[0]}, 2'b10);
    global_irq_en = 1'b0;
    foreach (bad[i]) begin
      arm(bad[i]);
      @(negedge mclk) check(csr_rdata[4:0], 5'h00);
      sync();
    end
    for (int i = 0; i < 4; i++) begin
      z = 16'($random(seed));
      d = 16'($random(seed));
      pg = {2'b00, z[6:1]};
      arm(8'h01);
      core.store(z, d, 1'b0);
      @(negedge mclk) check(buf_word[pg[5:0]], d);
      check({buf_loaded[pg[5:0]], csr_rdata[0]}, 2'b10);
      sync();
    end
    arm(8'h01);
    sync();
    arm(8'h11);
    @(negedge mclk) check(|buf_loaded, 1'b0);
    wait_idle();
    sync();
    // last readable page: busy, no stall
    want('{1'b1, 1'b0, 1'b0, 8'hDF, 8'h00}, '{1, 1, 1, 8'hFF, 8'h00});
    arm(8'h03);
    core.store({1'b1, 8'hDF, 7'h2A}, 16'h0000, 1'b0);
    sync();
    check({busy, stall, csr_rdata[6], csr_rdata[0]}, 4'hB);
    arm(8'h11);
    core.store(16'h0000, 16'h0000, 1'b0);
    @(negedge mclk) check(busy, 1'b1);
    wait_idle();
    check({busy, csr_rdata[1:0]}, 3'h4);
    sync();
    arm(8'h11);
    core.store(16'h0000, 16'h0000, 1'b0);
    @(negedge mclk) check(busy, 1'b0);
    sync();
    // random page in the halting range stalls the core
    pg = 8'hE0 + 8'({$random(seed)} % 32);
    want('{1'b0, 1'b1, 1'b0, pg, 8'h00}, '{1, 1, 1, 8'hFF, 8'h00});
    arm(8'h05);
    core.store({1'b0, pg, 7'h11}, 16'h0000, 1'b1);
    sync();
    check(stall, 1'b1);
    wait_idle();
    check({stall, csr_rdata[2]}, 2'b00);
    sync();
    d = 16'($random(seed));
    want('{1'b0, 1'b0, 1'b1, 8'h00, d[7:0]}, '{1, 1, 1, 8'h00, 8'hFF});
    arm(8'h09);
    core.store(16'h0000, d, 1'b0);
    wait_idle();
    check(csr_rdata[3], 1'b0);
    for (int b = 0; b < 4; b++) begin
      sync();
      rd_q.push_back(b[1] ? (b[0] ? sig_hi : sig_lo)
                          : (b[0] ? fuse_in : lock_in));
      arm(b[1] ? 8'h21 : 8'h09);
      core.load({15'h0000, b[0]});
      wait_idle();
    end
    sync();
    arm(8'h21);
    core.store(16'h0040, 16'hA5A5, 1'b0);
    wait_idle();
    check(buf_loaded[32], 1'b0);
    repeat (3) sync();
    check(rd_q.size() + req_q.size(), 0);
    final_report();
  end
endmodule
`default_nettype wire
